//--- src/ptc_clock_ctl.sv
// precision time clock: control word, time registers and running clock
// assumes a master that keeps strobes one cycle long and never both at once
`timescale 1ns/100ps
`default_nettype none
module ptc_clock_ctl (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [10:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  output logic [31:0] rtc_sec,
  output logic [29:0] rtc_ns,
  output logic [2:0] rtc_phase
);

  ptc_ref_if ref_bus ();

  ptc_ref_tick u_tick (
    .clk(clk),
    .rstn(rstn),
    .ref_io(ref_bus.src)
  );

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic run_q, run_d, dir_q, dir_d, cont_q, cont_d;
  logic [3:0] pend_q, pend_d;
  logic [15:0] nsl_q, nsl_d, nsh_q, nsh_d, sl_q, sl_d, sh_q, sh_d;
  logic [15:0] rl_q, rl_d, rh_q, rh_d, rdata_q, rdata_d;
  logic [2:0] ph_q, ph_d;
  // running clock
  logic [31:0] sec_q, sec_d, frac_q, frac_d;
  logic [29:0] ns_q, ns_d;

  logic tick, ctl_wr, time_wr;
  logic exec_rst, exec_ld, exec_step, exec_snap, exec_any;
  logic [29:0] ofs;
  logic [31:0] rate;
  logic rate_dn, adj_on;
  logic [30:0] ns_w, step_add, step_sub, tick_sum, inc_ns;
  logic [32:0] frac_up, frac_dn;

  assign tick = ref_bus.tick;
  assign ctl_wr = wr && (addr == ptc_pkg::ADDR_CTL);
  assign time_wr = wr && (addr == ptc_pkg::ADDR_NSL ||
    addr == ptc_pkg::ADDR_NSH || addr == ptc_pkg::ADDR_SL ||
    addr == ptc_pkg::ADDR_SH);

  // ---------------------------------------------------------------
  // command arbitration
  // ---------------------------------------------------------------
  // commands wait out tick cycles so a step never swallows 40 ns
  assign exec_rst = !tick && pend_q[ptc_pkg::PND_RST];
  assign exec_ld = !tick && !pend_q[ptc_pkg::PND_RST] &&
    pend_q[ptc_pkg::PND_LD];
  assign exec_step = !tick && pend_q[ptc_pkg::PND_STEP] &&
    pend_q[ptc_pkg::PND_LD:ptc_pkg::PND_RST] == 2'h0;
  assign exec_snap = !tick && pend_q[ptc_pkg::PND_SNAP] &&
    pend_q[ptc_pkg::PND_STEP:ptc_pkg::PND_RST] == 3'h0;
  assign exec_any = exec_rst || exec_ld || exec_step || exec_snap;

  // tick source steering
  assign ref_bus.run_en = run_q;
  assign ref_bus.clr = exec_rst;
  assign ref_bus.ld = exec_ld;
  assign ref_bus.ld_phase = ph_q;

  // ---------------------------------------------------------------
  // register file next state
  // ---------------------------------------------------------------
  always_comb begin
    run_d = run_q;
    dir_d = dir_q;
    cont_d = cont_q;
    nsl_d = nsl_q;
    nsh_d = nsh_q;
    sl_d = sl_q;
    sh_d = sh_q;
    ph_d = ph_q;
    rl_d = rl_q;
    rh_d = rh_q;
    // set wins over clear: a fresh write re-arms a finishing command
    pend_d = pend_q & ~{exec_snap, exec_step, exec_ld, exec_rst};
    if (ctl_wr) begin
      run_d = wdata[ptc_pkg::CTL_RUN_BIT];
      dir_d = wdata[ptc_pkg::CTL_DIR_BIT];
      cont_d = wdata[ptc_pkg::CTL_CONT_BIT];
      pend_d = pend_d | {wdata[ptc_pkg::CTL_SNAP_BIT],
        wdata[ptc_pkg::CTL_STEP_BIT], wdata[ptc_pkg::CTL_LOAD_BIT],
        wdata[ptc_pkg::CTL_RESET_BIT]};
    end
    if (wr) begin
      unique case (addr)
        ptc_pkg::ADDR_NSL: nsl_d = wdata;
        ptc_pkg::ADDR_NSH: nsh_d = wdata;
        ptc_pkg::ADDR_SL: sl_d = wdata;
        ptc_pkg::ADDR_SH: sh_d = wdata;
        ptc_pkg::ADDR_PHASE: ph_d = wdata[2:0];
        ptc_pkg::ADDR_RATEL: rl_d = wdata;
        ptc_pkg::ADDR_RATEH: rh_d = wdata;
        default: ;
      endcase
    end
    if (time_wr) begin
      ph_d = 3'h0;
    end
    // snapshot lands after any same-cycle host write
    if (exec_snap) begin
      nsl_d = ns_q[15:0];
      nsh_d = {2'h0, ns_q[29:16]};
      sl_d = sec_q[15:0];
      sh_d = sec_q[31:16];
      ph_d = ref_bus.phase;
    end
    // read data stand only in the cycle after the strobe
    rdata_d = 16'h0000;
    if (rd) begin
      unique case (addr)
        ptc_pkg::ADDR_CTL: rdata_d = {9'h000,
          pend_q[ptc_pkg::PND_STEP], dir_q, pend_q[ptc_pkg::PND_SNAP],
          pend_q[ptc_pkg::PND_LD], cont_q, run_q,
          pend_q[ptc_pkg::PND_RST]};
        ptc_pkg::ADDR_NSL: rdata_d = nsl_q;
        ptc_pkg::ADDR_NSH: rdata_d = nsh_q;
        ptc_pkg::ADDR_SL: rdata_d = sl_q;
        ptc_pkg::ADDR_SH: rdata_d = sh_q;
        ptc_pkg::ADDR_PHASE: rdata_d = {13'h0000, ph_q};
        ptc_pkg::ADDR_RATEL: rdata_d = rl_q;
        ptc_pkg::ADDR_RATEH: rdata_d = rh_q;
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      run_q <= ptc_pkg::CTL_RUN_RESET;
      dir_q <= 1'b0;
      cont_q <= 1'b0;
      pend_q <= 4'h0;
      nsl_q <= ptc_pkg::REG_RESET;
      nsh_q <= ptc_pkg::REG_RESET;
      sl_q <= ptc_pkg::REG_RESET;
      sh_q <= ptc_pkg::REG_RESET;
      ph_q <= 3'h0;
      rl_q <= ptc_pkg::REG_RESET;
      rh_q <= ptc_pkg::REG_RESET;
      rdata_q <= 16'h0000;
    end else begin
      run_q <= run_d;
      dir_q <= dir_d;
      cont_q <= cont_d;
      pend_q <= pend_d;
      nsl_q <= nsl_d;
      nsh_q <= nsh_d;
      sl_q <= sl_d;
      sh_q <= sh_d;
      ph_q <= ph_d;
      rl_q <= rl_d;
      rh_q <= rh_d;
      rdata_q <= rdata_d;
    end
  end

  // ---------------------------------------------------------------
  // clock arithmetic
  // ---------------------------------------------------------------
  // offsets are taken below one second; larger ones wrap once only
  assign ofs = {nsh_q[13:0], nsl_q};
  assign ns_w = {1'b0, ns_q};
  assign step_add = ns_w + {1'b0, ofs};
  assign step_sub = ns_w - {1'b0, ofs};
  assign rate = {2'h0, rh_q[13:0], rl_q};
  assign rate_dn = rh_q[ptc_pkg::RATEH_DIR_BIT];
  assign adj_on = cont_q && (rate != 32'h00000000);
  assign frac_up = {1'b0, frac_q} + {1'b0, rate};
  assign frac_dn = {1'b0, frac_q} - {1'b0, rate};
  // fraction in 2^-32 ns: carry or borrow moves one whole ns
  always_comb begin
    inc_ns = ptc_pkg::REF_NS;
    if (adj_on && !rate_dn && frac_up[32]) begin
      inc_ns = ptc_pkg::REF_NS + 31'h00000001;
    end else if (adj_on && rate_dn && frac_dn[32]) begin
      inc_ns = ptc_pkg::REF_NS - 31'h00000001;
    end
  end
  assign tick_sum = ns_w + inc_ns;

  always_comb begin
    sec_d = sec_q;
    ns_d = ns_q;
    frac_d = frac_q;
    if (exec_rst) begin
      sec_d = 32'h00000000;
      ns_d = 30'h00000000;
      frac_d = 32'h00000000;
    end else if (exec_ld) begin
      sec_d = {sh_q, sl_q};
      ns_d = ofs;
      frac_d = 32'h00000000;
    end else if (exec_step) begin
      if (dir_q) begin
        if (step_add >= ptc_pkg::NS_PER_SEC) begin
          ns_d = 30'(step_add - ptc_pkg::NS_PER_SEC);
          sec_d = sec_q + 32'h00000001;
        end else begin
          ns_d = step_add[29:0];
        end
      end else if (ns_q < ofs) begin
        ns_d = 30'(step_sub + ptc_pkg::NS_PER_SEC);
        sec_d = sec_q - 32'h00000001;
      end else begin
        ns_d = step_sub[29:0];
      end
    end else if (tick) begin
      if (adj_on) begin
        frac_d = rate_dn ? frac_dn[31:0] : frac_up[31:0];
      end
      if (tick_sum >= ptc_pkg::NS_PER_SEC) begin
        ns_d = 30'(tick_sum - ptc_pkg::NS_PER_SEC);
        sec_d = sec_q + 32'h00000001;
      end else begin
        ns_d = tick_sum[29:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sec_q <= 32'h00000000;
      ns_q <= 30'h00000000;
      frac_q <= 32'h00000000;
    end else begin
      sec_q <= sec_d;
      ns_q <= ns_d;
      frac_q <= frac_d;
    end
  end

  assign rdata = rdata_q;
  assign rtc_sec = sec_q;
  assign rtc_ns = ns_q;
  assign rtc_phase = ref_bus.phase;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_STEP_ADD: assert property (@(posedge clk) disable iff (!rstn)
    exec_step && dir_q && step_add < ptc_pkg::NS_PER_SEC
    |=> ns_q == $past(step_add[29:0]) && $stable(sec_q))
    else $error("step add result wrong");
  AST_STEP_SUB: assert property (@(posedge clk) disable iff (!rstn)
    exec_step && !dir_q && ns_q >= ofs
    |=> ns_q == $past(step_sub[29:0]))
    else $error("step subtract result wrong");
  AST_SNAP_COPY: assert property (@(posedge clk) disable iff (!rstn)
    exec_snap |=> nsl_q == $past(ns_q[15:0]) &&
    sh_q == $past(sec_q[31:16]) && ph_q == $past(ref_bus.phase))
    else $error("snapshot did not capture clock");
  AST_LOAD_TIME: assert property (@(posedge clk) disable iff (!rstn)
    exec_ld |=> sec_q == {$past(sh_q), $past(sl_q)} &&
    ns_q == $past(ofs))
    else $error("load did not copy time registers");
  AST_FROZEN: assert property (@(posedge clk) disable iff (!rstn)
    !run_q ##1 !run_q && !exec_any |=> $stable(ns_q) && $stable(sec_q))
    else $error("frozen clock moved");
  AST_RESET_CLK: assert property (@(posedge clk) disable iff (!rstn)
    exec_rst |=> sec_q == 32'h00000000 && ns_q == 30'h00000000)
    else $error("clock reset did not clear time");
  AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (!rstn)
    rd && addr == ptc_pkg::ADDR_CTL |=> rdata_q[15:7] == 9'h000)
    else $error("reserved control bits not zero");
  AST_PHASE_CLR: assert property (@(posedge clk) disable iff (!rstn)
    time_wr && !exec_snap |=> ph_q == 3'h0)
    else $error("phase not cleared on time write");
  AST_PLAIN_TICK: assert property (@(posedge clk) disable iff (!rstn)
    tick && !adj_on && tick_sum < ptc_pkg::NS_PER_SEC
    |=> ns_q == $past(ns_q) + 30'(ptc_pkg::REF_NS) && $stable(frac_q))
    else $error("unadjusted tick not 40 ns");
  AST_CMD_DONE: assert property (@(posedge clk) disable iff (!rstn)
    ctl_wr && wdata[ptc_pkg::CTL_SNAP_BIT] ##1 !ctl_wr [*5]
    |-> !pend_q[ptc_pkg::PND_SNAP])
    else $error("snapshot bit stuck");
  AST_ORDER: assert property (@(posedge clk) disable iff (!rstn)
    pend_q[ptc_pkg::PND_RST] && pend_q[ptc_pkg::PND_LD] && !tick
    |=> pend_q[ptc_pkg::PND_LD] || ctl_wr == 1'b1 || $past(ctl_wr))
    else $error("load ran before reset");

endmodule
`default_nettype wire

//--- src/ptc_pkg.sv
// package for the precision time clock control block
// assumes a 100 MHz system clock and a 16-bit register port
package ptc_pkg;

  // ---------------------------------------------------------------
  // register byte addresses
  // ---------------------------------------------------------------
  localparam logic [10:0] ADDR_CTL = 11'h600;
  localparam logic [10:0] ADDR_NSL = 11'h604;
  localparam logic [10:0] ADDR_NSH = 11'h606;
  localparam logic [10:0] ADDR_SL = 11'h608;
  localparam logic [10:0] ADDR_SH = 11'h60A;
  localparam logic [10:0] ADDR_PHASE = 11'h60C;
  localparam logic [10:0] ADDR_RATEL = 11'h610;
  localparam logic [10:0] ADDR_RATEH = 11'h612;

  // ---------------------------------------------------------------
  // control word fields
  // ---------------------------------------------------------------
  localparam int CTL_RESET_BIT = 0;
  localparam int CTL_RUN_BIT = 1;
  localparam int CTL_CONT_BIT = 2;
  localparam int CTL_LOAD_BIT = 3;
  localparam int CTL_SNAP_BIT = 4;
  localparam int CTL_DIR_BIT = 5;
  localparam int CTL_STEP_BIT = 6;
  localparam int CTL_RSVD_LO = 7;
  localparam int RATEH_DIR_BIT = 15;
  localparam logic CTL_RUN_RESET = 1'b1;
  localparam logic [15:0] REG_RESET = 16'h0000;

  // pending command slots, in order of priority
  localparam int PND_RST = 0;
  localparam int PND_LD = 1;
  localparam int PND_STEP = 2;
  localparam int PND_SNAP = 3;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int REF_PERIOD_NS = 40;
  localparam int PHASE_STEP_NS = 8;
  localparam int REF_DIV = REF_PERIOD_NS / CLK_PERIOD_NS;
  localparam logic [1:0] REF_LAST = 2'(REF_DIV - 1);
  localparam logic [30:0] REF_NS = 31'(REF_PERIOD_NS);
  localparam logic [30:0] NS_PER_SEC = 31'h3B9ACA00;

endpackage

//--- src/ptc_ref_if.sv
// reference tick carrier between the control core and the tick source
// assumes both ends share clk
`timescale 1ns/100ps
`default_nettype none
interface ptc_ref_if;
  logic run_en;
  logic clr;
  logic ld;
  logic [2:0] ld_phase;
  logic tick;
  logic [2:0] phase;
  modport src (input run_en, clr, ld, ld_phase, output tick, phase);
  modport sink (output run_en, clr, ld, ld_phase, input tick, phase);
endinterface
`default_nettype wire

//--- src/ptc_ref_tick.sv
// 25 MHz reference tick and 8 ns sub-phase source
// assumes clk at 100 MHz; four system cycles make one reference cycle
`timescale 1ns/100ps
`default_nettype none
module ptc_ref_tick (
  input wire logic clk,
  input wire logic rstn,
  ptc_ref_if.src ref_io
);

  logic [1:0] cnt_q, cnt_d;
  logic tick_q, tick_d;
  logic [1:0] ld_cnt;
  logic [2:0] phase_q, phase_d;

  // ---------------------------------------------------------------
  // phase to sub-cycle mapping
  // ---------------------------------------------------------------
  // 8 ns codes land on the 10 ns slot that contains them
  // six bits: code 4 times 8 ns is 32 and must not wrap
  always_comb begin
    ld_cnt = 2'h3;
    if (ref_io.ld_phase < 3'h5) begin
      ld_cnt = 2'((6'(ref_io.ld_phase) * 6'(ptc_pkg::PHASE_STEP_NS)) /
        6'(ptc_pkg::CLK_PERIOD_NS));
    end
  end

  // ---------------------------------------------------------------
  // divider
  // ---------------------------------------------------------------
  // counter holds while the clock is frozen, save on clear or load, so no tick escapes
  always_comb begin
    cnt_d = cnt_q;
    tick_d = 1'b0;
    if (ref_io.clr) begin
      cnt_d = 2'h0;
    end else if (ref_io.ld) begin
      cnt_d = ld_cnt;
    end else if (ref_io.run_en) begin
      if (cnt_q == ptc_pkg::REF_LAST) begin
        cnt_d = 2'h0;
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 2'h1;
      end
    end
    // slot index times 10 ns over 8 ns is the slot number itself
    phase_d = {1'b0, cnt_d};
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= 2'h0;
      tick_q <= 1'b0;
      phase_q <= 3'h0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
      phase_q <= phase_d;
    end
  end

  assign ref_io.tick = tick_q;
  assign ref_io.phase = phase_q;

endmodule
`default_nettype wire

//--- tb/ptc_host_model.sv
// host processor model: drives the register port of the clock block
// assumes one clk shared with the block; strobes change after rising edges
`timescale 1ns/100ps
`default_nettype none
module ptc_host_model (
  input wire logic clk,
  input wire logic [15:0] rdata,
  output logic [10:0] addr,
  output logic [15:0] wdata,
  output logic wr,
  output logic rd
);
  // ---------------------------------------------------------------
  // bus cycles
  // ---------------------------------------------------------------
  // idle bus from time zero so the block never sees an unknown strobe
  initial begin
    addr = 11'h000;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
  end

  // one-cycle write; callers put time values before any load command
  task automatic wr_reg(input logic [10:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    wdata <= ~d; // stale data must not look valid
  endtask

  // one-cycle read; data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [10:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
endmodule
`default_nettype wire

//--- tb/test_ptp_clock_control.sv
// self-checking bench for the precision time clock control block
// assumes the host model file is compiled first; single 100 MHz clock
`timescale 1ns/100ps
`default_nettype none
module test_ptp_clock_control;
  logic clk;
  logic rstn;
  logic [10:0] addr;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic [15:0] rdata;
  logic [31:0] rtc_sec;
  logic [29:0] rtc_ns;
  logic [2:0] rtc_phase;
  int err_count = 0;
  int num_checks = 0;

  // ---------------------------------------------------------------
  // design and host
  // ---------------------------------------------------------------
  ptc_clock_ctl dut_u (.clk(clk), .rstn(rstn), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rtc_sec(rtc_sec),
    .rtc_ns(rtc_ns), .rtc_phase(rtc_phase));
  ptc_host_model host_u (.clk(clk), .rdata(rdata), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd));

  // clock: 10 ns period
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask

  task automatic wr_ctl(input logic [15:0] d);
    host_u.wr_reg(ptc_pkg::ADDR_CTL, d);
    repeat (6) @(posedge clk); // commands finish within a few cycles
    #1;
  endtask

  task automatic rd_chk(input string what, input logic [10:0] a,
                        input logic [15:0] exp);
    logic [15:0] d;
    host_u.rd_reg(a, d);
    chk(what, {16'h0000, exp}, {16'h0000, d});
  endtask

  // ns advance over a span of system cycles, from any tick phase
  task automatic span_ns(input int cyc, output logic [31:0] delta);
    logic [29:0] a;
    @(posedge clk);
    #1 a = rtc_ns;
    repeat (cyc) @(posedge clk);
    #1 delta = 32'(rtc_ns - a);
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    rd_chk("ctl_reset", ptc_pkg::ADDR_CTL, 16'h0002);
    rd_chk("nsl_reset", ptc_pkg::ADDR_NSL, 16'h0000);
    rd_chk("unmapped", 11'h602, 16'h0000);
    $display("test reset values done");
  endtask

  task automatic t_run;
    logic [31:0] d;
    span_ns(40, d);
    chk("ns_per_40cyc", 32'd400, d);
    chk("phase_range", 1, 32'(rtc_phase < 3'd5));
    wr_ctl(16'h0000);
    span_ns(20, d);
    chk("frozen_ns", 0, d);
    wr_ctl(16'h0002);
    $display("test run and freeze done");
  endtask

  task automatic t_cmds;
    wr_ctl(16'h0000);
    host_u.wr_reg(ptc_pkg::ADDR_PHASE, 16'h0002);
    host_u.wr_reg(ptc_pkg::ADDR_NSL, 16'h2345);
    rd_chk("phase_cleared", ptc_pkg::ADDR_PHASE, 16'h0000);
    host_u.wr_reg(ptc_pkg::ADDR_NSH, 16'h0001);
    host_u.wr_reg(ptc_pkg::ADDR_SL, 16'hBEEF);
    host_u.wr_reg(ptc_pkg::ADDR_SH, 16'h0012);
    wr_ctl(16'h0008);
    chk("load_ns", 32'h0001_2345, rtc_ns);
    chk("load_sec", 32'h0012_BEEF, rtc_sec);
    host_u.wr_reg(ptc_pkg::ADDR_NSL, 16'h0064);
    host_u.wr_reg(ptc_pkg::ADDR_NSH, 16'h0000);
    wr_ctl(16'h0060);
    chk("step_add", 32'h0001_23A9, rtc_ns);
    rd_chk("step_selfclr", ptc_pkg::ADDR_CTL, 16'h0020);
    wr_ctl(16'h0040);
    chk("step_sub", 32'h0001_2345, rtc_ns);
    wr_ctl(16'h0010);
    rd_chk("snap_nsl", ptc_pkg::ADDR_NSL, 16'h2345);
    rd_chk("snap_nsh", ptc_pkg::ADDR_NSH, 16'h0001);
    rd_chk("snap_selfclr", ptc_pkg::ADDR_CTL, 16'h0000);
    // the snapshot left the high word set: clear it for a small offset
    host_u.wr_reg(ptc_pkg::ADDR_NSL, 16'h0010);
    host_u.wr_reg(ptc_pkg::ADDR_NSH, 16'h0000);
    host_u.wr_reg(ptc_pkg::ADDR_SL, 16'h0000);
    host_u.wr_reg(ptc_pkg::ADDR_SH, 16'h0000);
    // load before step: offset register equals the loaded value
    wr_ctl(16'h0068);
    chk("load_then_step", 32'h0000_0020, rtc_ns);
    // reset before load: loaded value must survive
    wr_ctl(16'h0009);
    chk("reset_then_load", 32'h0000_0010, rtc_ns);
    // phase code 4 (32 ns) lands in the last 10 ns slot
    host_u.wr_reg(ptc_pkg::ADDR_PHASE, 16'h0004);
    wr_ctl(16'h0008);
    chk("load_phase", 3, rtc_phase);
    wr_ctl(16'h0001);
    chk("reset_ns", 0, rtc_ns);
    chk("reset_sec", 0, rtc_sec);
    rd_chk("reset_selfclr", ptc_pkg::ADDR_CTL, 16'h0000);
    wr_ctl(16'hFF82);
    rd_chk("ctl_reserved", ptc_pkg::ADDR_CTL, 16'h0002);
    $display("test commands done");
  endtask

  task automatic t_rate;
    logic [31:0] d;
    // near 0.25 ns per tick: one extra ns about every fourth tick
    host_u.wr_reg(ptc_pkg::ADDR_RATEL, 16'hFFFF);
    host_u.wr_reg(ptc_pkg::ADDR_RATEH, 16'h3FFF);
    wr_ctl(16'h0002);
    span_ns(160, d);
    chk("cont_off", 32'd1600, d);
    wr_ctl(16'h0006);
    span_ns(160, d);
    chk("rate_up", 1, 32'(d >= 1608 && d <= 1611));
    host_u.wr_reg(ptc_pkg::ADDR_RATEH, 16'hBFFF);
    span_ns(160, d);
    chk("rate_down", 1, 32'(d >= 1589 && d <= 1592));
    host_u.wr_reg(ptc_pkg::ADDR_RATEL, 16'h0000);
    host_u.wr_reg(ptc_pkg::ADDR_RATEH, 16'h0000);
    span_ns(160, d);
    chk("rate_zero", 32'd1600, d);
    $display("test rate correction done");
  endtask

  // ---------------------------------------------------------------
  // verdict
  // ---------------------------------------------------------------
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // about nine hundred cycles of work; a generous cap cuts a hang short
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    conclude();
  end

  // main sequence
  initial begin
    rstn = 1'b0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_run();
    t_cmds();
    t_rate();
    conclude();
  end
endmodule
`default_nettype wire
